// *** spi_ctrl.sv ***
// Serial port with its control register, reached over APB
//
// Chosen here: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`include "spi_ctrl_map.svh"
module spi_ctrl (
    input wire logic clk, // System clock, 10 MHz
    input wire logic rst_b, // Synchronous reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB direction
    input wire logic [11:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error on unmapped address
    input wire logic global_irq_en, // Core global interrupt enable
    input wire logic irq_ack, // Pulse on interrupt entry
    output logic irq, // Serial interrupt request
    output logic sclk_o, // Serial clock out
    output logic sclk_oe, // Serial clock drive enable
    input wire logic sclk_i, // Serial clock pin level
    output logic mosi_o, // Master data out
    output logic mosi_oe, // Master data drive enable
    input wire logic mosi_i, // Master data pin level
    output logic miso_o, // Slave data out
    output logic miso_oe, // Slave data drive enable
    input wire logic miso_i, // Slave data pin level
    input wire logic ss_b_i, // Slave select pin level, low active
    input wire logic ss_is_input // Select pin configured as input
);
    logic [7:0] ctrl_q;
    logic [7:0] tx_q;
    logic [7:0] rx_q;
    logic done_q;
    logic armed_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic irq_q;
    logic sclk_q;
    logic sclk_oe_q;
    logic mosi_q;
    logic mosi_oe_q;
    logic miso_q;
    logic miso_oe_q;
    spi_ctrl_pkg::xfer_state_e state_q;
    logic [6:0] tick_q;
    logic [4:0] edge_q;
    logic [3:0] sync1_q;
    logic [3:0] sync2_q;
    logic sclk_prev_q;

    // Two-flop synchronisers for sclk, mosi, miso, select
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sync1_q <= 4'h0;
            sync2_q <= 4'h0;
            sclk_prev_q <= 1'b0;
        end else begin
            sync1_q <= {sclk_i, mosi_i, miso_i, ss_b_i};
            sync2_q <= sync1_q;
            sclk_prev_q <= sync2_q[3];
        end
    end

    wire sclk_s = sync2_q[3];
    wire mosi_s = sync2_q[2];
    wire miso_s = sync2_q[1];
    wire ss_b_s = sync2_q[0];

    // Control fields
    wire en = ctrl_q[`BIT_ENABLE];
    wire lsb_first = ctrl_q[`BIT_ORDER];
    wire is_master = ctrl_q[`BIT_MASTER];
    wire clock_idle_polarity = ctrl_q[`BIT_CLOCK_IDLE_POLARITY];
    wire clock_sample_phase = ctrl_q[`BIT_CLOCK_SAMPLE_PHASE];

    // APB decode; a write or read takes effect on the ready edge
    wire acc = psel && penable && pready_q;
    wire wr = acc && pwrite;
    wire rd = acc && !pwrite;
    wire hit_ctrl = (paddr == `CTRL_ADDR);
    wire hit_stat = (paddr == `STAT_ADDR);
    wire hit_data = (paddr == `DATA_ADDR);
    wire mapped = hit_ctrl || hit_stat || hit_data;

    // Rate code to half period; divider count is even so halves are equal
    wire [6:0] half_len = (ctrl_q[1:0] == 2'b00) ? `HALF_DIV4 :
        (ctrl_q[1:0] == 2'b01) ? `HALF_DIV16 :
        (ctrl_q[1:0] == 2'b10) ? `HALF_DIV64 : `HALF_DIV128;

    // Mode fault: another master pulls select low
    wire fault = en && is_master && ss_is_input && !ss_b_s;

    // Master and slave edge timing
    wire half_tick = (state_q == spi_ctrl_pkg::ST_MASTER) && (tick_q == half_len - 7'h01);
    wire slave_sel = en && !is_master && !ss_b_s;
    wire slave_edge = (state_q == spi_ctrl_pkg::ST_SLAVE) && (sclk_s != sclk_prev_q);
    wire edge_ev = half_tick || slave_edge;
    // Edge number about to happen is edge_q; even ones are leading
    wire leading = !edge_q[0];
    wire sample_ev = edge_ev && (leading ^ clock_sample_phase);
    wire last_edge = edge_ev && (edge_q == `EDGES_PER_BYTE - 5'h01);
    wire start_m = wr && hit_data && en && is_master && (state_q == spi_ctrl_pkg::ST_IDLE);

    // Bit in flight: changes on trailing edge (phase 0) or leading (phase 1)
    wire [4:0] edges_done = edge_ev ? edge_q + 5'h01 : edge_q;
    wire [4:0] shifted = clock_sample_phase ? ((edges_done == 5'h00) ? 5'h00 : edges_done - 5'h01) : edges_done;
    wire [2:0] pos = shifted[3:1];
    wire [2:0] bit_idx = lsb_first ? pos : 3'h7 - pos;
    wire out_bit = tx_q[bit_idx];
    wire in_bit = is_master ? miso_s : mosi_s;

    // Control register; fault clears master, software must set it again
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ctrl_q <= `CTRL_RESET;
        end else if (fault) begin
            ctrl_q[`BIT_MASTER] <= 1'b0;
        end else if (wr && hit_ctrl) begin
            ctrl_q <= pwdata[7:0];
        end
    end

    // Transfer sequencer
    always_ff @(posedge clk) begin
        if (!rst_b || !en || fault) begin
            state_q <= spi_ctrl_pkg::ST_IDLE;
            tick_q <= 7'h00;
            edge_q <= 5'h00;
        end else begin
            unique case (state_q)
                spi_ctrl_pkg::ST_IDLE: begin
                    tick_q <= 7'h00;
                    edge_q <= 5'h00;
                    if (start_m) begin
                        state_q <= spi_ctrl_pkg::ST_MASTER;
                    end else if (slave_sel) begin
                        state_q <= spi_ctrl_pkg::ST_SLAVE;
                    end
                end
                spi_ctrl_pkg::ST_MASTER: begin
                    tick_q <= half_tick ? 7'h00 : tick_q + 7'h01;
                    if (half_tick) begin
                        edge_q <= edge_q + 5'h01;
                    end
                    if (last_edge) begin
                        state_q <= spi_ctrl_pkg::ST_IDLE;
                    end
                end
                spi_ctrl_pkg::ST_SLAVE: begin
                    // Select release ends the frame, whatever the edge count
                    if (!slave_sel) begin
                        state_q <= spi_ctrl_pkg::ST_IDLE;
                    end else if (slave_edge) begin
                        edge_q <= last_edge ? 5'h00 : edge_q + 5'h01;
                    end
                end
                default: begin
                    state_q <= spi_ctrl_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Data shifting: sample edge fills receive byte in chosen order
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            tx_q <= 8'h00;
            rx_q <= 8'h00;
        end else begin
            if (wr && hit_data && state_q == spi_ctrl_pkg::ST_IDLE) begin
                tx_q <= pwdata[7:0];
            end
            if (sample_ev) begin
                rx_q <= lsb_first ? {in_bit, rx_q[7:1]} : {rx_q[6:0], in_bit};
            end
        end
    end

    // Done flag: set wins; cleared by entry or status read then data access
    wire clr_seq = acc && hit_data && armed_q;
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            done_q <= 1'b0;
            armed_q <= 1'b0;
        end else begin
            if (last_edge || fault) begin
                done_q <= 1'b1;
            end else if (irq_ack || clr_seq) begin
                done_q <= 1'b0;
            end
            if (rd && hit_stat && done_q) begin
                armed_q <= 1'b1;
            end else if (clr_seq || !done_q) begin
                armed_q <= 1'b0;
            end
        end
    end

    // Interrupt request, registered so the port is a flop
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= ctrl_q[`BIT_IRQ_EN] && done_q && global_irq_en && !irq_ack;
        end
    end

    // Pin drivers; clock idles at polarity level between frames
    wire m_run = (state_q == spi_ctrl_pkg::ST_MASTER);
    wire sclk_d = (m_run && half_tick) ? ~sclk_q : (m_run ? sclk_q : clock_idle_polarity);
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sclk_q <= 1'b0;
            sclk_oe_q <= 1'b0;
            mosi_q <= 1'b0;
            mosi_oe_q <= 1'b0;
            miso_q <= 1'b0;
            miso_oe_q <= 1'b0;
        end else begin
            sclk_q <= sclk_d;
            sclk_oe_q <= en && is_master && !fault;
            mosi_oe_q <= en && is_master && !fault;
            mosi_q <= out_bit;
            miso_oe_q <= slave_sel;
            miso_q <= out_bit;
        end
    end

    // APB slave: one wait state, error on unmapped address
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= psel && penable && !pready_q;
            pslverr_q <= psel && penable && !pready_q && !mapped;
            if (psel && penable && !pready_q) begin
                prdata_q <= hit_ctrl ? {24'h00_0000, ctrl_q} :
                    hit_stat ? {24'h00_0000, done_q, 7'h00} :
                    hit_data ? {24'h00_0000, rx_q} : 32'h0000_0000;
            end
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign irq = irq_q;
    assign sclk_o = sclk_q;
    assign sclk_oe = sclk_oe_q;
    assign mosi_o = mosi_q;
    assign mosi_oe = mosi_oe_q;
    assign miso_o = miso_q;
    assign miso_oe = miso_oe_q;
endmodule

// *** spi_ctrl_map.svh ***
// Register map, field positions and rate constants of the serial port control block
// Contract
// - Interrupt needs enable bit, flag, global enable
// - Module works only while enable bit set
// - Order bit one shifts LSB first
// - Master bit one drives clock, else slave
// - Select pin low in master, with pin set as input: fault
// - Polarity bit sets clock idle level, edges
// - Two rate bits choose clock divider
// - Rates divide by 4, 16, 64, 128
// - Done flag set per transfer, cleared
`ifndef SPI_CTRL_MAP_SVH
`define SPI_CTRL_MAP_SVH

// Register indices; byte address is four times the index
`define CTRL_IDX 8'h4C
`define STAT_IDX 8'h4D
`define DATA_IDX 8'h4E
`define CTRL_ADDR 12'h130
`define STAT_ADDR 12'h134
`define DATA_ADDR 12'h138

// Control and status fields
`define CTRL_RESET 8'h00
`define BIT_IRQ_EN 7
`define BIT_ENABLE 6
`define BIT_ORDER 5
`define BIT_MASTER 4
`define BIT_CLOCK_IDLE_POLARITY 3
`define BIT_CLOCK_SAMPLE_PHASE 2
`define BIT_DONE 7

// Half-period lengths in system clocks for the four rate codes
`define HALF_DIV4 7'h02
`define HALF_DIV16 7'h08
`define HALF_DIV64 7'h20
`define HALF_DIV128 7'h40

// Clock edges in one byte transfer
`define EDGES_PER_BYTE 5'h10

`endif

// *** spi_ctrl_pkg.sv ***
// Types shared by the serial port control block
package spi_ctrl_pkg;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_MASTER = 2'b01,
        ST_SLAVE = 2'b10
    } xfer_state_e;
endpackage

// *** spi_ctrl_props.sv ***
// Concurrent checks on the serial port control ports
`timescale 1ns/1ps
`include "spi_ctrl_map.svh"
module spi_ctrl_props (
    input wire logic clk, // System clock
    input wire logic rst_b, // Sync reset, low active
    input wire logic psel, // APB select
    input wire logic penable, // APB access
    input wire logic [11:0] paddr, // APB address
    input wire logic [31:0] prdata, // APB read data
    input wire logic pready, // APB ready
    input wire logic pslverr, // APB error
    input wire logic global_irq_en, // Core enable
    input wire logic irq, // Serial interrupt
    input wire logic sclk_o, // Serial clock out
    input wire logic sclk_oe, // Serial clock enable
    input wire logic ss_b_i, // Select pin
    input wire logic ss_is_input // Select is input
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // One wait state, then a single ready pulse
    apb_wait_a: assert property (psel && penable && !pready |=> pready) else $error("ready late");
    ready_pulse_a: assert property (pready |=> !pready) else $error("ready held");
    err_map_a: assert property (pready && !(paddr inside {`CTRL_ADDR, `STAT_ADDR, `DATA_ADDR}) |-> pslverr)
        else $error("no error on hole");
    err_data_a: assert property (pslverr |-> pready && prdata == 32'h0000_0000) else $error("error data");
    upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h00_0000) else $error("upper bits set");
    irq_gate_a: assert property (!global_irq_en |=> !irq) else $error("irq while masked");
    // Shortest half period is two clocks, so no back-to-back toggles
    clk_half_a: assert property (sclk_oe && $changed(sclk_o) |=> $stable(sclk_o)) else $error("clock fast");
    mode_fault_a: assert property ((ss_is_input && !ss_b_i)[*6] |-> !sclk_oe) else $error("no fault");
    cover property (pslverr);
    cover property ($rose(irq));
    cover property ($fell(sclk_oe));
endmodule

// *** spi_dev_model.sv ***
// Behavioural serial peripheral on the far side of the link
`timescale 1ns/1ps
module spi_dev_model (
    input wire logic sclk, // Serial clock line
    input wire logic mosi, // Data from master
    input wire logic sel_b, // Device select, low active
    input wire logic [7:0] ctl, // Mirror of control setting
    input wire logic [7:0] tx, // Byte to return
    output logic miso, // Data to master
    output logic [7:0] rx // Byte received
);
    int s = 0;
    initial miso = 1'b0;
    // Released line shows the inverse of its last bit, never a stale level
    always @(sel_b) begin
        s = 0;
        miso = sel_b ? ~miso : (ctl[5] ? tx[0] : tx[7]);
    end
    // Leading edge leaves the idle level; phase picks the sample edge
    always @(sclk) if (!sel_b) begin
        if ((sclk != ctl[3]) ^ ctl[2]) begin
            rx = ctl[5] ? {mosi, rx[7:1]} : {rx[6:0], mosi};
            s++;
        end else if (s < 8) miso = ctl[5] ? tx[s] : tx[7 - s];
    end
endmodule

// *** spi_ctrl_tb_top.sv ***
// Self-checking bench of the serial port control block
`timescale 1ns/1ps
`include "spi_ctrl_map.svh"
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin error_cnt++; \
    $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module spi_ctrl_tb_top;
    logic clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, global_irq_en = 0, irq_ack = 0;
    logic ss_b_i = 1, ss_is_input = 0, dev_sel_b = 1, pready, pslverr, e, irq, sclk_o, sclk_oe;
    logic mosi_o, mosi_oe, miso_o, miso_oe, miso;
    logic ext_tog = 0, ext_mosi = 0; // Remote master clock toggle and data
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, r;
    logic [7:0] ctl = 0, dev_tx = 0, dev_rx;
    int error_cnt = 0, n_compared = 0;
    // Pin levels from the controller's drive enables
    wire sclk = sclk_oe ? sclk_o : ctl[3] ^ ext_tog;
    wire mosi = mosi_oe ? mosi_o : (ss_b_i ? ~mosi_o : ext_mosi);
    wire miso_w = miso_oe ? miso_o : miso;
    spi_ctrl u_spi_ctrl (.clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .global_irq_en, .irq_ack, .irq, .sclk_o, .sclk_oe, .sclk_i(sclk), .mosi_o, .mosi_oe,
        .mosi_i(mosi), .miso_o, .miso_oe, .miso_i(miso_w), .ss_b_i, .ss_is_input);
    spi_dev_model u_spi_dev_model (.sclk, .mosi, .sel_b(dev_sel_b), .ctl, .tx(dev_tx), .miso, .rx(dev_rx));
    initial forever #50 clk = ~clk;
    task final_report;
        if (error_cnt == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // One APB transfer; only the watchdog ends a hung wait; result left in r and e
    task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= {24'h00_0000, d};
        @(posedge clk);
        penable <= 1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata; e = pslverr;
        psel <= 0; penable <= 0;
        @(posedge clk);
    endtask
    task t_regs;
        apb(0, `CTRL_ADDR, 0); `CHK(r, 32'h0000_0000)
        apb(1, `CTRL_ADDR, 8'h2F); apb(0, `CTRL_ADDR, 0); `CHK(r, 32'h0000_002F)
        apb(0, 12'h13C, 0); `CHK({e, r}, {1'b1, 32'h0000_0000})
        ctl = 8'h1C; apb(1, `CTRL_ADDR, ctl); apb(1, `DATA_ADDR, 8'h55);
        repeat (20) @(posedge clk);
        `CHK({sclk_oe, sclk_o}, 2'b01)
    endtask
    // Master byte: idle level, half period, flag, bits both ways
    task t_xfer(input logic [7:0] c, input logic [7:0] tx, input logic [7:0] rxb);
        int k, h;
        ctl = c; dev_tx = rxb; k = 0;
        h = (c[1:0] == 0) ? 4 / 2 : (c[1:0] == 1) ? 16 / 2 : (c[1:0] == 2) ? 64 / 2 : 128 / 2;
        apb(1, `CTRL_ADDR, c);
        @(posedge clk); // Let the idle level settle before the device is selected
        dev_sel_b <= 0; apb(1, `DATA_ADDR, tx);
        `CHK({sclk_oe, sclk_o}, {1'b1, c[3]})
        while (sclk_o === c[3] && k < 200) begin @(posedge clk); k++; end
        k = 0;
        while (sclk_o !== c[3] && k < 200) begin @(posedge clk); k++; end
        `CHK(k, h)
        k = 0;
        do apb(0, `STAT_ADDR, 0); while (r[7] !== 1'b1 && ++k < 400);
        `CHK(r[7], 1'b1)
        dev_sel_b <= 1;
        `CHK(sclk_o, c[3])
        if (!c[7]) begin
            apb(0, `DATA_ADDR, 0);
            if (c[1:0] != 0) `CHK({dev_rx, r[7:0]}, {tx, rxb})
            apb(0, `STAT_ADDR, 0); `CHK(r[7], 1'b0)
        end
    endtask
    task t_irq;
        global_irq_en <= 1; t_xfer(8'hD1, 8'h3C, 8'hC3);
        `CHK(irq, 1'b1)
        irq_ack <= 1; @(posedge clk); irq_ack <= 0; repeat (2) @(posedge clk);
        `CHK(irq, 1'b0)
        global_irq_en <= 0; t_xfer(8'hD1, 8'h0F, 8'hE1); repeat (2) @(posedge clk);
        `CHK(irq, 1'b0)
        irq_ack <= 1; @(posedge clk); irq_ack <= 0;
    endtask
    // Remote master clocks one byte in mode 0, MSB first, with select held low
    task t_slave;
        logic [7:0] got;
        logic [7:0] sb;
        sb = 8'h3C;
        got = 8'h00;
        ctl = 8'h40;
        apb(1, `CTRL_ADDR, 8'h40);
        apb(1, `DATA_ADDR, 8'hA5);
        ss_b_i <= 0;
        repeat (6) @(posedge clk);
        `CHK({sclk_oe, miso_oe}, 2'b01)
        // Slow edges leave room for the two-flop synchronisers
        for (int b = 0; b < 8; b++) begin
            ext_mosi <= sb[7 - b];
            repeat (6) @(posedge clk);
            got[7 - b] = miso_w;
            ext_tog <= 1;
            repeat (6) @(posedge clk);
            ext_tog <= 0;
        end
        repeat (6) @(posedge clk);
        apb(0, `STAT_ADDR, 0); `CHK(r[7], 1'b1)
        apb(0, `DATA_ADDR, 0); `CHK(r[7:0], 8'h3C)
        `CHK(got, 8'hA5)
        ss_b_i <= 1;
    endtask
    // Select pulled low while master: drop to slave, flag set, rewrite to resume
    task t_fault;
        apb(1, `CTRL_ADDR, 8'h51); ss_is_input <= 1; ss_b_i <= 0;
        repeat (8) @(posedge clk);
        ss_b_i <= 1; apb(0, `CTRL_ADDR, 0);
        `CHK({r[7:0], sclk_oe}, {8'h41, 1'b0})
        apb(0, `STAT_ADDR, 0); `CHK(r[7], 1'b1)
        apb(0, `DATA_ADDR, 0); apb(1, `CTRL_ADDR, 8'h51);
        @(posedge clk); // Drive enable follows one cycle after the write
        `CHK(sclk_oe, 1'b1)
        ss_is_input <= 0;
    endtask
    // Sequence: reset, registers, all modes and orders, all rates, interrupt, slave, fault
    initial begin
        repeat (3) @(posedge clk);
        rst_b <= 1;
        @(posedge clk);
        t_regs;
        for (int i = 0; i < 8; i++) t_xfer({2'b01, i[2], 1'b1, i[1:0], 2'b01}, 8'hC1 + i[7:0], 8'h1A + i[7:0]);
        for (int i = 0; i < 4; i++) t_xfer({6'h14, i[1:0]}, 8'h8D, 8'h71);
        t_irq;
        t_slave;
        t_fault;
        final_report;
    end
    // Watchdog, well beyond the expected run
    initial begin
        #3_000_000;
        error_cnt++;
        final_report;
    end
endmodule
bind spi_ctrl spi_ctrl_props u_spi_ctrl_props (.clk, .rst_b, .psel, .penable, .paddr, .prdata, .pready,
    .pslverr, .global_irq_en, .irq, .sclk_o, .sclk_oe, .ss_b_i, .ss_is_input);
